/* File: fprp_pkg.sv */
// Constants, types and helpers for the command block.
// Assumes a 125 MHz mclk and a host framing commands with chip select.
// Function
// (R1) Password read gives the stored password only before password mode.
// (R2) Password read sends 64 bits, low byte first, top bit first, on sck fall.
// (R3) Each further 64 clocks repeat the password.
// (R4) Password program needs the write enable latch set.
// (R5) Password program is ignored in password mode.
// (R6) Password program is opcode plus exactly 64 bits, else discarded.
// (R7) Password program runs timed, holds busy, flags error, clears the latch.
// (R8) Password unlock is opcode plus exactly 64 bits, else ignored.
// (R9) Unlock runs a timed check; mismatch sets error and keeps busy.
// (R10) Error and busy after mismatch stay until clear status or reset.
// (R11) A matching unlock sets the lock bit.
// (R12) Soft reset reloads volatile bits but keeps freeze and lock.
// (R13) Soft reset restores block protect only while freeze is zero.
// (R14) Reset runs on chip select rise, then stays busy for recovery.
// (R15) Reset after an unfinished power-up takes the full power-up time.
// (R16) Four-line mode takes the opcode in two clocks, high nibble first.
// (R17) Reset runs only directly after reset-arm.
// (R18) Legacy reset acts only while its configuration bit is one.
// (R19) Eight ones on line zero leave continuous read mode.
// (R20) Host sends mode exit after system reset and before soft reset.
// (R21) Deep power-down is taken only while idle.
// (R22) Deep power-down needs chip select rise right after bit eight.
// (R23) While powered down only release is recognised.
// (R24) Release returns to normal after the release interval.
// (R25) The reset pin also leaves deep power-down.
// (R26) Ignored commands leave the output undriven and change nothing.
// (R27) Soft reset leaves non-volatile configuration bits untouched.
package fprp_pkg;

    localparam int CLK_MHZ = 125;

    localparam logic [7:0] OP_PW_READ   = 8'he7;
    localparam logic [7:0] OP_PW_PROG   = 8'he8;
    localparam logic [7:0] OP_PW_UNLOCK = 8'he9;
    localparam logic [7:0] OP_WRITE_ENABLE_CMD      = 8'h06;
    localparam logic [7:0] OP_CLR_STAT  = 8'h30;
    localparam logic [7:0] OP_RST_ARM   = 8'h66;
    localparam logic [7:0] OP_RST       = 8'h99;
    localparam logic [7:0] OP_RST_OLD   = 8'hf0;
    localparam logic [7:0] OP_DPD       = 8'hb9;
    localparam logic [7:0] OP_RELEASE   = 8'hab;

    localparam logic [6:0] NB_OP    = 7'h08;
    localparam logic [6:0] NB_FRAME = 7'h48;
    localparam logic [6:0] NB_QUAD  = 7'h04;
    localparam logic [6:0] NB_ONE   = 7'h01;
    localparam logic [6:0] NB_MAX   = 7'h7f;
    localparam logic [6:0] NB_LAST1 = 7'h07;
    localparam logic [5:0] RD_ONE   = 6'h01;
    localparam int         TMR_W    = 24;
    localparam logic [TMR_W-1:0] TMR_ONE = 24'h000001;
    localparam logic [63:0] PW_ERASED = 64'hffffffffffffffff;

    localparam int T_PROG_NS  = 200000;
    localparam int T_CHECK_NS = 100000;
    localparam int T_RPH_NS   = 20000;
    localparam int T_PU_NS    = 300000;
    localparam int T_DPD_NS   = 3000;
    localparam int T_RES_NS   = 5000;

    // All times round down, never below one cycle.
    function automatic int fprp_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int PROG_CYC  = fprp_cyc(T_PROG_NS);
    localparam int CHECK_CYC = fprp_cyc(T_CHECK_NS);
    localparam int RPH_CYC   = fprp_cyc(T_RPH_NS);
    localparam int PU_CYC    = fprp_cyc(T_PU_NS);
    localparam int DPD_CYC   = fprp_cyc(T_DPD_NS);
    localparam int RES_CYC   = fprp_cyc(T_RES_NS);

    // Password bit position for serial bit i: byte i/8, bit 7 - i%8.
    function automatic logic [5:0] fprp_pw_bit(input logic [5:0] i);
        return {i[5:3], ~i[2:0]};
    endfunction

    typedef struct packed {
        logic       cs_n;
        logic       sck;
        logic [3:0] io;
    } fprp_link_t;

    typedef struct packed {
        logic write_in_progress;
        logic write_enable_latch;
        logic program_error;
        logic sector_protect_lock;
    } fprp_status_t;

endpackage

/* File: fprp_cmd.sv */
// Command interpreter for password, software reset, mode exit and deep power-down.
// Assumes asynchronous link pins and an mclk much faster than sck.
`timescale 1ns/1ps

module fprp_cmd #(
    parameter int PROG_CYC_P  = fprp_pkg::PROG_CYC,
    parameter int CHECK_CYC_P = fprp_pkg::CHECK_CYC,
    parameter int PU_CYC_P    = fprp_pkg::PU_CYC
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire fprp_pkg::fprp_link_t  link_pins,
    output logic                       so_out,
    output logic                       so_oe,
    input  wire logic                  hw_reset_n,
    input  wire logic                  por_complete,
    input  wire logic                  four_line_command_mode,
    input  wire logic                  password_mode_n,
    input  wire logic                  prog_fault,
    input  wire logic                  freeze_set,
    input  wire logic                  lock_por_value,
    input  wire logic [2:0]            nv_block_protect,
    input  wire logic                  nv_legacy_reset_en,
    input  wire logic                  cont_read_enter,
    output fprp_pkg::fprp_status_t     status,
    output logic [2:0]                 block_protect,
    output logic                       legacy_reset_en,
    output logic                       freeze,
    output logic                       cont_read_mode,
    output logic                       busy,
    output logic                       powered_down
);
    import fprp_pkg::*;

    typedef enum logic [7:0] {
        S_IDLE  = 8'h01,
        S_PROG  = 8'h02,
        S_CHECK = 8'h04,
        S_FAIL  = 8'h08,
        S_RESET = 8'h10,
        S_ENTER = 8'h20,
        S_DPD   = 8'h40,
        S_WAKE  = 8'h80
    } fprp_state_t;

    // ****
    // Pin synchronisers
    // ****
    fprp_link_t  link_s1;
    fprp_link_t  link_s2;
    logic        hwr_s1;
    logic        hwr_s2;
    logic        sck_d;
    logic        cs_d;

    always_ff @(posedge mclk) begin
        if (rst) begin
            link_s1 <= '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};
            link_s2 <= '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};
            hwr_s1  <= 1'b1;
            hwr_s2  <= 1'b1;
            sck_d   <= 1'b0;
            cs_d    <= 1'b1;
        end else begin
            link_s1 <= link_pins;
            link_s2 <= link_s1;
            hwr_s1  <= hw_reset_n;
            hwr_s2  <= hwr_s1;
            sck_d   <= link_s2.sck;
            cs_d    <= link_s2.cs_n;
        end
    end

    logic cs_low;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;

    assign cs_low   = ~link_s2.cs_n;
    assign sck_rise = link_s2.sck & ~sck_d;
    assign sck_fall = ~link_s2.sck & sck_d;
    assign cs_rise  = link_s2.cs_n & ~cs_d;
    assign cs_fall  = ~link_s2.cs_n & cs_d;

    // ****
    // Command state
    // ****
    fprp_state_t      state, next_state;
    logic [TMR_W-1:0] tmr, next_tmr;
    logic [6:0]       nbits, next_nbits;
    logic [7:0]       opcode, next_opcode;
    logic [63:0]      pw_in, next_pw_in;
    logic [63:0]      pw_hold, next_pw_hold;
    logic [63:0]      pw_store, next_pw_store;
    logic             ones_ok, next_ones_ok;
    logic             rd_on, next_rd_on;
    logic [5:0]       rd_idx, next_rd_idx;
    logic             so, next_so;
    fprp_status_t     st, next_st;
    logic [2:0]       bp, next_bp;
    logic             cfg3, next_cfg3;
    logic             frz, next_frz;
    logic             arm, next_arm;
    logic             cont, next_cont;
    logic             load_nv, next_load_nv;

    always_comb begin
        logic [6:0] dofs;
        logic       n8;
        logic       n72;
        logic       do_sw;
        logic       done;
        dofs          = nbits - NB_OP;
        n8            = (nbits == NB_OP);
        n72           = (nbits == NB_FRAME);
        do_sw         = 1'b0;
        done          = (tmr == TMR_ONE);
        next_state    = state;
        next_tmr      = (tmr > TMR_ONE) ? tmr - TMR_ONE : tmr;
        next_nbits    = nbits;
        next_opcode   = opcode;
        next_pw_in    = pw_in;
        next_pw_hold  = pw_hold;
        next_pw_store = pw_store;
        next_ones_ok  = ones_ok;
        next_rd_on    = rd_on;
        next_rd_idx   = rd_idx;
        next_so       = so;
        next_st       = st;
        next_bp       = bp;
        next_cfg3     = cfg3;
        next_frz      = frz | freeze_set;
        next_arm      = arm;
        next_cont     = cont | cont_read_enter;
        next_load_nv  = 1'b0;

        // Serial shift-in and password read-out.
        if (cs_fall) begin
            next_nbits   = '0;
            next_ones_ok = 1'b1;
            next_rd_on   = 1'b0;
            next_rd_idx  = '0;
            next_so      = 1'b0;
        end else if (cs_low && sck_rise) begin
            next_ones_ok = ones_ok & link_s2.io[0];
            if (four_line_command_mode && !cont && nbits < NB_OP) begin
                next_opcode = {opcode[3:0], link_s2.io};    // R16
                next_nbits  = nbits + NB_QUAD;
            end else if (nbits < NB_OP) begin
                next_opcode = {opcode[6:0], link_s2.io[0]};
                next_nbits  = nbits + NB_ONE;
            end else begin
                if (nbits < NB_FRAME) begin
                    next_pw_in[fprp_pw_bit(dofs[5:0])] = link_s2.io[0];    // R6 R8
                end
                next_nbits = (nbits == NB_MAX) ? nbits : nbits + NB_ONE;
            end
            if (cont && nbits == NB_LAST1 && ones_ok && link_s2.io[0]) begin
                next_cont = cont_read_enter;    // R19
            end
        end
        if (cs_low && !rd_on && n8 && opcode == OP_PW_READ && state == S_IDLE && !cont) begin
            next_rd_on = 1'b1;
        end
        if (rd_on && cs_low && sck_fall) begin
            next_so     = password_mode_n ? pw_store[fprp_pw_bit(rd_idx)] : 1'b0;    // R1 R2
            next_rd_idx = rd_idx + RD_ONE;    // R3
        end
        if (cs_rise) begin
            next_rd_on = 1'b0;
        end

        // Frame end decode and timed operations.
        case (state)
            S_IDLE, S_FAIL: begin
                if (cs_rise && !cont && nbits >= NB_OP) begin
                    next_arm = n8 && opcode == OP_RST_ARM;    // R17
                    if (n8 && ((opcode == OP_RST && arm) || (opcode == OP_RST_OLD && cfg3))) begin
                        do_sw = 1'b1;    // R14 R17 R18
                    end else if (n8 && opcode == OP_CLR_STAT) begin
                        next_st.program_error     = 1'b0;    // R10
                        next_st.write_in_progress = 1'b0;
                        next_state                = S_IDLE;
                    end else if (state == S_IDLE) begin
                        if (n8 && opcode == OP_WRITE_ENABLE_CMD) begin
                            next_st.write_enable_latch = 1'b1;
                        end else if (n72 && opcode == OP_PW_PROG && st.write_enable_latch
                                     && password_mode_n) begin
                            next_pw_hold              = pw_in;    // R4 R5 R6
                            next_st.write_in_progress = 1'b1;    // R7
                            next_tmr                  = TMR_W'(PROG_CYC_P);
                            next_state                = S_PROG;
                        end else if (n72 && opcode == OP_PW_UNLOCK) begin
                            next_pw_hold              = pw_in;    // R8
                            next_st.write_in_progress = 1'b1;    // R9
                            next_tmr                  = TMR_W'(CHECK_CYC_P);
                            next_state                = S_CHECK;
                        end else if (n8 && opcode == OP_DPD && !st.write_in_progress) begin
                            next_tmr   = TMR_W'(DPD_CYC);    // R21 R22
                            next_state = S_ENTER;
                        end
                    end
                end
            end
            S_PROG: begin
                if (done) begin
                    next_pw_store              = pw_hold;    // R7
                    next_st.program_error      = prog_fault;
                    next_st.write_in_progress  = 1'b0;
                    next_st.write_enable_latch = 1'b0;
                    next_state                 = S_IDLE;
                end
            end
            S_CHECK: begin
                if (done) begin
                    if (pw_hold == pw_store) begin
                        next_st.sector_protect_lock = 1'b1;    // R11
                        next_st.write_in_progress   = 1'b0;
                        next_state                  = S_IDLE;
                    end else begin
                        next_st.program_error = 1'b1;    // R9
                        next_state            = S_FAIL;
                    end
                end
            end
            S_DPD: begin
                if (cs_rise && n8 && opcode == OP_RELEASE) begin
                    next_tmr   = TMR_W'(RES_CYC);    // R23 R24
                    next_state = S_WAKE;
                end
            end
            S_RESET, S_WAKE: begin
                if (done) begin
                    next_state = S_IDLE;    // R14 R24
                end
            end
            S_ENTER: begin
                if (done) begin
                    next_state = S_DPD;    // R22
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase

        // Software reset keeps freeze, lock and all non-volatile bits.
        if (do_sw) begin
            next_st.write_in_progress  = 1'b0;    // R12 R27
            next_st.write_enable_latch = 1'b0;
            next_st.program_error      = 1'b0;
            next_arm                   = 1'b0;
            next_cont                  = 1'b0;
            next_cfg3                  = nv_legacy_reset_en;
            if (!frz) begin
                next_bp = nv_block_protect;    // R13
            end
            next_tmr   = por_complete ? TMR_W'(RPH_CYC) : TMR_W'(PU_CYC_P);    // R15
            next_state = S_RESET;
        end

        // Power-on load and reset pin restart state, status and volatile bits, including power-down; the stored password is kept.
        if (load_nv || !hwr_s2) begin
            next_state = S_IDLE;    // R25
            next_tmr   = TMR_ONE;
            next_st    = '{write_in_progress: 1'b0, write_enable_latch: 1'b0,
                           program_error: 1'b0, sector_protect_lock: lock_por_value};
            next_bp    = nv_block_protect;
            next_cfg3  = nv_legacy_reset_en;
            next_frz   = 1'b0;
            next_arm   = 1'b0;
            next_cont  = 1'b0;
            next_rd_on = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state    <= S_IDLE;
            tmr      <= TMR_ONE;
            nbits    <= '0;
            opcode   <= '0;
            pw_in    <= '0;
            pw_hold  <= '0;
            pw_store <= PW_ERASED;
            ones_ok  <= 1'b0;
            rd_on    <= 1'b0;
            rd_idx   <= '0;
            so       <= 1'b0;
            st       <= '0;
            bp       <= '0;
            cfg3     <= 1'b0;
            frz      <= 1'b0;
            arm      <= 1'b0;
            cont     <= 1'b0;
            load_nv  <= 1'b1;
        end else begin
            state    <= next_state;
            tmr      <= next_tmr;
            nbits    <= next_nbits;
            opcode   <= next_opcode;
            pw_in    <= next_pw_in;
            pw_hold  <= next_pw_hold;
            pw_store <= next_pw_store;
            ones_ok  <= next_ones_ok;
            rd_on    <= next_rd_on;
            rd_idx   <= next_rd_idx;
            so       <= next_so;
            st       <= next_st;
            bp       <= next_bp;
            cfg3     <= next_cfg3;
            frz      <= next_frz;
            arm      <= next_arm;
            cont     <= next_cont;
            load_nv  <= next_load_nv;
        end
    end

    // ****
    // Outputs
    // ****
    assign so_out          = so;
    assign so_oe           = rd_on & cs_low;    // R26
    assign status          = st;
    assign block_protect   = bp;
    assign legacy_reset_en = cfg3;
    assign freeze          = frz;
    assign cont_read_mode  = cont;
    assign busy            = (state != S_IDLE) && (state != S_DPD);
    assign powered_down    = (state == S_DPD);

endmodule // fprp_cmd

/* File: fprp_cmd_asserts.sv */
// Concurrent checks on the command block's ports.
// Assumes one mclk domain; rst disables the checks.
`timescale 1ns/1ps

module fprp_cmd_asserts #(
    parameter int PROG_CYC_P  = 20,
    parameter int CHECK_CYC_P = 20
) (
    input wire logic                   mclk,
    input wire logic                   rst,
    input wire fprp_pkg::fprp_link_t   link_pins,
    input wire logic                   so_oe,
    input wire logic                   hw_reset_n,
    input wire logic                   lock_por_value,
    input wire fprp_pkg::fprp_status_t status,
    input wire logic [2:0]             block_protect,
    input wire logic                   freeze,
    input wire logic                   busy,
    input wire logic                   powered_down
);
    import fprp_pkg::*;

    localparam int LIM = (PROG_CYC_P > CHECK_CYC_P ? PROG_CYC_P : CHECK_CYC_P) + 1;
    logic [23:0] wip_run, next_wip_run;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ****
    // Cycles a timed operation has run without an error.
    // ****
    always_comb begin
        next_wip_run = (status.write_in_progress && !status.program_error) ? wip_run + 24'h1 : 24'h0;
    end
    always_ff @(posedge mclk) begin
        wip_run <= rst ? 24'h0 : next_wip_run;
    end

    sequence s_cs_quiet;
        link_pins.cs_n [*4];
    endsequence
    sequence s_cs_risen;
        link_pins.cs_n && $past(link_pins.cs_n, 2);
    endsequence

    a_oe_needs_cs: assert property (s_cs_quiet |-> !so_oe)
        else $error("output driven with cs high");
    a_ops_on_cs: assert property (
        ($rose(busy) || $rose(status.write_in_progress)) |-> s_cs_risen)
        else $error("operation without cs rise");
    a_wip_span: assert property (wip_run <= LIM)
        else $error("timed operation too long");
    a_dpd_when_idle: assert property (powered_down |-> !status.write_in_progress)
        else $error("power-down during operation");
    a_dpd_silent: assert property (powered_down |-> !so_oe)
        else $error("output driven in power-down");
    a_dpd_entry: assert property ($rose(powered_down) |-> $past(busy))
        else $error("power-down without entry delay");
    a_lock_cause: assert property (
        $changed(status.sector_protect_lock) |-> status.sector_protect_lock == lock_por_value
            || $past(status.write_in_progress) || $past(status.write_in_progress, 2))
        else $error("lock changed without cause");
    a_bp_frozen: assert property (freeze && $past(freeze) |-> $stable(block_protect))
        else $error("protect changed while frozen");
    a_freeze_kept: assert property (
        $fell(freeze) |-> !$past(hw_reset_n, 2) || !$past(hw_reset_n, 3) || !$past(hw_reset_n, 4))
        else $error("freeze cleared without pin");

endmodule // fprp_cmd_asserts

bind fprp_cmd fprp_cmd_asserts #(.PROG_CYC_P(PROG_CYC_P), .CHECK_CYC_P(CHECK_CYC_P)) u_chk (
    .mclk(mclk), .rst(rst), .link_pins(link_pins), .so_oe(so_oe), .hw_reset_n(hw_reset_n),
    .lock_por_value(lock_por_value), .status(status), .block_protect(block_protect),
    .freeze(freeze), .busy(busy), .powered_down(powered_down));

/* File: fprp_host.sv */
// Host model framing commands on the link.
// Assumes an 8 ns mclk; sck idles low between frames.
`timescale 1ns/1ps

module fprp_host (
    input  wire logic          mclk,
    input  wire logic          so_out,
    input  wire logic          so_oe,
    output fprp_pkg::fprp_link_t link
);
    import fprp_pkg::*;

    initial link = '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};

    // One sck period; samples so_out just before the fall.
    task automatic clk_bit(input logic [3:0] v, output logic s);
        link.io = v;
        repeat (4) @(posedge mclk);
        #1 link.sck = 1'b1;
        repeat (4) @(posedge mclk);
        #1 s = so_oe ? so_out : 1'bx;
        link.sck = 1'b0;
    endtask

    task automatic xfer(input logic [7:0] op, input logic quad, input logic [63:0] d,
                        input int nd, output logic [127:0] rd);
        int   i;
        logic s;
        rd = '0;
        @(posedge mclk);
        #1 link.cs_n = 1'b0;
        for (i = 0; i < 8; i += (quad ? 4 : 1))
            clk_bit(quad ? op[7-i-:4] : {~link.io[3:1], op[7-i]}, s);
        for (i = 0; i < nd; i++) begin
            clk_bit({~link.io[3:1], d[(i % 64) / 8 * 8 + 7 - i % 8]}, s);
            rd[i] = s;
        end
        repeat (4) @(posedge mclk);
        #1 link.cs_n = 1'b1;
        link.io = ~link.io;
        repeat (8) @(posedge mclk);
    endtask

endmodule // fprp_host

/* File: test_flash_password_reset_powerdown_cmds.sv */
// Self-checking bench for the command block.
// Assumes fprp_host drives the link and the checker is bound.
`timescale 1ns/1ps

module test_flash_password_reset_powerdown_cmds;
    import fprp_pkg::*;

    localparam int          PUCYC = 40;
    localparam logic [63:0] PW    = 64'h0123456789abcdef;

    logic         mclk;
    logic         rst = 1'b1, hw_reset_n = 1'b1, por_complete = 1'b1, password_mode_n = 1'b1;
    logic         four_line_command_mode = 1'b0, prog_fault = 1'b0, freeze_set = 1'b0;
    logic         cont_read_enter = 1'b0, nv_legacy_reset_en = 1'b0;
    logic [2:0]   nv_block_protect = 3'h5;
    fprp_link_t   link;
    fprp_status_t status;
    logic         so_out, so_oe, legacy_reset_en, freeze, cont_read_mode, busy, powered_down;
    logic [2:0]   block_protect;
    logic [127:0] rd;
    int           err_total = 0;
    int           tests_run = 0;
    int           n;

    fprp_cmd #(.PROG_CYC_P(20), .CHECK_CYC_P(20), .PU_CYC_P(PUCYC)) u_dut (
        .mclk(mclk), .rst(rst), .link_pins(link), .so_out(so_out), .so_oe(so_oe),
        .hw_reset_n(hw_reset_n), .por_complete(por_complete),
        .four_line_command_mode(four_line_command_mode), .password_mode_n(password_mode_n),
        .prog_fault(prog_fault), .freeze_set(freeze_set), .lock_por_value(1'b0),
        .nv_block_protect(nv_block_protect), .nv_legacy_reset_en(nv_legacy_reset_en),
        .cont_read_enter(cont_read_enter), .status(status), .block_protect(block_protect),
        .legacy_reset_en(legacy_reset_en), .freeze(freeze), .cont_read_mode(cont_read_mode),
        .busy(busy), .powered_down(powered_down));
    fprp_host u_host (.mclk(mclk), .so_out(so_out), .so_oe(so_oe), .link(link));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // ****
    // Shared helpers.
    // ****
    task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [63:0] ser(input logic [63:0] p);
        for (int i = 0; i < 64; i++) ser[i] = p[i / 8 * 8 + 7 - i % 8];
    endfunction

    task automatic cmd(input logic [7:0] op, input logic [63:0] d = '0, input int nd = 0);
        u_host.xfer(op, four_line_command_mode, d, nd, rd);
    endtask

    task automatic settle(input int lim);
        n = 0;
        while ((busy !== 1'b0 || status.write_in_progress !== 1'b0) && n < lim) begin
            @(posedge mclk);
            n++;
        end
        chk("settle", n < lim, 1'b1);
    endtask

    task automatic wt(input int c);
        repeat (c) @(posedge mclk);
    endtask

    task automatic pulse(ref logic s);
        @(posedge mclk);
        #1 s = 1'b1;
        @(posedge mclk);
        #1 s = 1'b0;
    endtask

    task automatic hw_pulse();
        @(posedge mclk);
        #1 hw_reset_n = 1'b0;
        wt(6);
        #1 hw_reset_n = 1'b1;
        wt(6);
    endtask

    // ****
    // Scenarios.
    // ****
    task automatic t_password();
        cmd(OP_PW_PROG, PW, 64);
        chk("prog no wel", status.write_in_progress, 1'b0);
        cmd(OP_WRITE_ENABLE_CMD);
        chk("wel", status.write_enable_latch, 1'b1);
        cmd(OP_PW_PROG, PW, 63);
        chk("short prog", status.write_in_progress, 1'b0);
        cmd(OP_PW_PROG, PW, 64);
        chk("prog wip", status.write_in_progress, 1'b1);
        settle(100);
        chk("prog wel", status.write_enable_latch, 1'b0);
        chk("prog perr", status.program_error, 1'b0);
        cmd(OP_PW_READ, '0, 128);
        chk("pw read", rd, {ser(PW), ser(PW)});
        prog_fault = 1'b1;
        cmd(OP_WRITE_ENABLE_CMD);
        cmd(OP_PW_PROG, PW, 64);
        settle(100);
        prog_fault = 1'b0;
        chk("fault perr", status.program_error, 1'b1);
        cmd(OP_CLR_STAT);
        password_mode_n = 1'b0;
        cmd(OP_WRITE_ENABLE_CMD);
        cmd(OP_PW_PROG, ~PW, 64);
        chk("prog pw mode", status.write_in_progress, 1'b0);
        cmd(OP_PW_READ, '0, 64);
        chk("hidden read", rd[63:0], 64'h0);
        password_mode_n = 1'b1;
        cmd(OP_PW_READ, '0, 64);
        chk("kept pw", rd[63:0], ser(PW));
    endtask

    task automatic t_unlock();
        cmd(OP_PW_UNLOCK, ~PW, 64);
        wt(60);
        chk("fail wip", status.write_in_progress, 1'b1);
        chk("fail perr", status.program_error, 1'b1);
        cmd(OP_DPD);
        wt(400);
        chk("dpd in op", powered_down, 1'b0);
        cmd(OP_CLR_STAT);
        chk("clr wip", status.write_in_progress, 1'b0);
        chk("clr perr", status.program_error, 1'b0);
        cmd(OP_PW_UNLOCK, PW, 64);
        settle(100);
        chk("lock", status.sector_protect_lock, 1'b1);
    endtask

    task automatic t_reset();
        nv_block_protect = 3'h2;
        pulse(freeze_set);
        cmd(OP_RST_ARM);
        cmd(OP_WRITE_ENABLE_CMD);
        cmd(OP_RST);
        chk("split reset", busy, 1'b0);
        cmd(OP_RST_OLD);
        chk("legacy off", busy, 1'b0);
        pulse(cont_read_enter);
        cmd(8'hff);
        chk("cont exit", cont_read_mode, 1'b0);
        four_line_command_mode = 1'b1;
        cmd(OP_RST_ARM);
        cmd(OP_RST);
        four_line_command_mode = 1'b0;
        settle(5000);
        chk("reset span", n >= RPH_CYC - 8 && n <= RPH_CYC, 1'b1);
        chk("freeze kept", freeze, 1'b1);
        chk("lock kept", status.sector_protect_lock, 1'b1);
        chk("bp frozen", block_protect, 3'h5);
        chk("reset wel", status.write_enable_latch, 1'b0);
        nv_legacy_reset_en = 1'b1;
        hw_pulse();
        chk("hw freeze", freeze, 1'b0);
        chk("hw lock", status.sector_protect_lock, 1'b0);
        chk("hw legacy", legacy_reset_en, 1'b1);
        por_complete = 1'b0;
        nv_block_protect = 3'h6;
        cmd(OP_RST_OLD);
        settle(5000);
        por_complete = 1'b1;
        chk("pu span", n >= PUCYC - 8 && n <= PUCYC, 1'b1);
        chk("bp reload", block_protect, 3'h6);
    endtask

    task automatic t_dpd();
        cmd(OP_DPD, '0, 1);
        wt(400);
        chk("long dpd", powered_down, 1'b0);
        cmd(OP_DPD);
        wt(400);
        chk("dpd", powered_down, 1'b1);
        cmd(OP_WRITE_ENABLE_CMD);
        chk("dpd wel", status.write_enable_latch, 1'b0);
        cmd(OP_PW_READ, '0, 8);
        chk("dpd read", rd[7:0], 8'hxx);
        cmd(OP_RELEASE);
        settle(700);
        chk("release", powered_down, 1'b0);
        cmd(OP_DPD);
        wt(400);
        hw_pulse();
        chk("hw wake", powered_down, 1'b0);
    endtask

    task automatic wrap_up();
        if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #400000;
        err_total++;
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge mclk);
        #1 rst = 1'b0;
        wt(4);
        chk("bp after reset", block_protect, 3'h5);
        t_password();
        t_unlock();
        t_reset();
        t_dpd();
        wrap_up();
    end

endmodule // test_flash_password_reset_powerdown_cmds
